//--- rtl/msf_monitor_frame_sender.sv
// Monitor-mode status frame sender: register image, frame builder, byte handshake
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
module msf_monitor_frame_sender import msf_pkg::*; #(
   parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // Wishbone classic slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADR_W-1:0]  wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // Instrument bus data lines
   input  wire logic [7:0]        dio_i,
   output logic      [7:0]        dio_o,
   output logic                   dio_oe_o,
   // Instrument bus management and handshake
   input  wire logic              atn_n_i,
   input  wire logic              dav_i,
   output logic                   dav_o,
   output logic                   dav_oe_o,
   input  wire logic              rfd_i,
   input  wire logic              dac_i,
   // Front panel and status
   input  wire logic              remote_i,
   output logic                   talking_o
);

   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] freq;
      logic [31:0] mode;
      logic [31:0] aux;
      logic        ack;
      logic [31:0] rdat;
      logic        talking;
      logic        dav_seen;
      logic [3:0]  ptr;
      logic [3:0]  last_sent;
      logic [3:0]  talk_cnt;
      msf_hs_t     hs;
      logic [7:0]  dio;
      logic [3:0]  slot;
   } msf_state_t;

   msf_state_t st_q;
   msf_state_t st_d;
   msf_pins_t  pin_raw;
   msf_pins_t  pin_s;
   msf_item_t  push_item;
   msf_item_t  pop_item;
   logic       push_valid;
   logic       push_ready;
   logic       pop_valid;
   logic       pop_ready;
   logic       flush;
   logic       wb_req;
   logic       atn_act;
   logic       dav_rise;
   logic       stop;
   logic       sent_now;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [3:0] next_slot(input logic [3:0] s);
      next_slot = (s == LAST_SLOT) ? HDR_SLOT : s + 4'h1;
   endfunction

   // Out-of-range digits are held at nine so no digit byte can pose as a header
   function automatic logic [3:0] bcd_sat(input logic [3:0] d);
      bcd_sat = (d > BCD_MAX) ? BCD_MAX : d;
   endfunction

   function automatic logic [4:0] det_code(input logic [2:0] sel);
      case (sel)
         SEL_LSB: det_code = DET_LSB;
         SEL_USB: det_code = DET_USB;
         SEL_ISB: det_code = DET_ISB;
         SEL_CW:  det_code = DET_CW;
         SEL_FM:  det_code = DET_FM;
         default: det_code = DET_AM;
      endcase
   endfunction

   function automatic logic [31:0] wr_bytes(input logic [31:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
      wr_bytes = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) wr_bytes[8*i +: 8] = wdat[8*i +: 8];
      end
   endfunction

   function automatic logic [7:0] build_byte(input logic [3:0]  slot,
                                             input logic [31:0] ctrl,
                                             input logic [31:0] freq,
                                             input logic [31:0] mode,
                                             input logic [31:0] aux,
                                             input logic        remote);
      logic [2:0] bw;
      logic [1:0] gain;
      logic [1:0] msd;
      bw   = mode[MODE_BW_LSB +: 3];
      gain = mode[MODE_GAIN_LSB +: 2];
      msd  = freq[29:28];
      bw   = (bw > BW_MAX) ? BW_MAX : bw;
      gain = (gain > GAIN_MODE_MAX) ? GAIN_MODE_MAX : gain;
      msd  = (msd > MSD_MAX) ? MSD_MAX : msd;
      case (slot)
         HDR_SLOT:     build_byte = {HDR_TAG, ctrl[CTRL_B5_BIT],
                                     ctrl[CTRL_ADDR_LSB +: 5]};                       // R3
         FINE_SLOT:    build_byte = ctrl[CTRL_OPT_BIT] ?
                                    {4'h0, bcd_sat(freq[3:0])} : NO_OPT_BYTE;          // R10
         CTL_SLOT:     build_byte = {remote, 2'b00, mode[MODE_NEG_BIT], gain, msd};   // R11
         FRQ_HI_SLOT:  build_byte = {bcd_sat(freq[27:24]), bcd_sat(freq[23:20])};     // R12
         FRQ_MID_SLOT: build_byte = {bcd_sat(freq[19:16]), bcd_sat(freq[15:12])};     // R12
         FRQ_LO_SLOT:  build_byte = {bcd_sat(freq[11:8]), bcd_sat(freq[7:4])};        // R12
         DETBW_SLOT:   build_byte = {bw, det_code(mode[MODE_DET_LSB +: 3])};          // R8 R9
         BFO_SLOT:     build_byte = {bcd_sat(aux[7:4]), bcd_sat(aux[3:0])};
         GAIN_SLOT:    build_byte = (aux[15:8] > GAIN_MAX) ? GAIN_MAX : aux[15:8];   // R5
         default:      build_byte = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and byte FIFO

   assign pin_raw = {remote_i, atn_n_i, dav_i, rfd_i, dac_i, dio_i};

   msf_sync #(
      .WIDTH ($bits(msf_pins_t))
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (pin_raw),
      .sync_o  (pin_s)
   );

   msf_fifo #(
      .WIDTH ($bits(msf_item_t)),
      .DEPTH (FIFO_DEPTH_P)
   ) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .flush_i     (flush),
      .in_valid_i  (push_valid),
      .in_ready_o  (push_ready),
      .in_data_i   (push_item),
      .out_valid_o (pop_valid),
      .out_ready_i (pop_ready),
      .out_data_o  (pop_item)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_d           = st_q;
      wb_req         = wb_cyc_i & wb_stb_i & ~st_q.ack;
      atn_act        = ~pin_s.atn_n;                                                  // R13
      dav_rise       = pin_s.dav & ~st_q.dav_seen;
      stop           = atn_act | ~st_q.talking;
      sent_now       = (st_q.hs == HS_DRIVE) & pin_s.dac;
      push_valid     = ~stop;
      pop_ready      = (st_q.hs == HS_IDLE) & ~stop;
      flush          = stop;
      push_item.slot = st_q.ptr;
      push_item.data = build_byte(st_q.ptr, st_q.ctrl, st_q.freq, st_q.mode, st_q.aux,
                                  pin_s.remote);
      st_d.dav_seen  = pin_s.dav;

      // Register access; ack comes one cycle after the request and drops the next
      st_d.ack = wb_req;
      if (wb_req) begin
         if (wb_we_i) begin
            case ({wb_adr_i[ADR_W-1:2], 2'b00})
               OFF_CTRL: st_d.ctrl = wr_bytes(st_q.ctrl, wb_dat_i, wb_sel_i);
               OFF_FREQ: st_d.freq = wr_bytes(st_q.freq, wb_dat_i, wb_sel_i);
               OFF_MODE: st_d.mode = wr_bytes(st_q.mode, wb_dat_i, wb_sel_i);
               OFF_AUX:  st_d.aux  = wr_bytes(st_q.aux, wb_dat_i, wb_sel_i);
               default:  st_d.ctrl = st_q.ctrl;
            endcase
         end
         case ({wb_adr_i[ADR_W-1:2], 2'b00})
            OFF_CTRL:   st_d.rdat = {24'h00_0000, st_q.ctrl[7:0]};
            OFF_FREQ:   st_d.rdat = {2'b00, st_q.freq[29:0]};
            OFF_MODE:   st_d.rdat = {23'h00_0000, st_q.mode[8:0]};
            OFF_AUX:    st_d.rdat = {16'h0000, st_q.aux[15:0]};
            OFF_STATUS: st_d.rdat = {16'h0000, st_q.talk_cnt, st_q.last_sent, st_q.ptr,
                                     2'b00, pin_s.remote, st_q.talking};             // R11
            default:    st_d.rdat = 32'h0000_0000;
         endcase
      end

      // Address words while attention is asserted decide whether this end talks
      if (!st_q.ctrl[CTRL_EN_BIT]) begin
         st_d.talking = 1'b0;
      end else if (atn_act && dav_rise && pin_s.dio[6:5] == TALK_GRP) begin             // R13
         if (pin_s.dio[4:0] == st_q.ctrl[CTRL_ADDR_LSB +: 5] &&
             pin_s.dio[4:0] != UNTALK_ADDR) begin
            st_d.talking  = 1'b1;                                                     // R1
            st_d.talk_cnt = st_q.talk_cnt + 4'h1;
         end else begin
            st_d.talking = 1'b0;
         end
      end

      // One full handshake per byte
      if (sent_now) begin
         st_d.last_sent = st_q.slot;                                                  // R2
      end
      case (st_q.hs)
         HS_IDLE: begin
            if (pop_ready && pop_valid) begin
               st_d.dio  = pop_item.data;
               st_d.slot = pop_item.slot;
               st_d.hs   = HS_WAIT_RFD;
            end
         end
         HS_WAIT_RFD: begin
            if (pin_s.rfd && !pin_s.dac) st_d.hs = HS_DRIVE;                          // R14
         end
         HS_DRIVE: begin
            if (pin_s.dac) st_d.hs = HS_RELEASE;                                      // R14
         end
         HS_RELEASE: begin
            if (!pin_s.dac) st_d.hs = HS_IDLE;                                        // R14
         end
         default: st_d.hs = HS_IDLE;
      endcase

      // Prefetched bytes are dropped on a stop; the pointer rewinds to the slot
      // after the last byte the listener accepted, so nothing is skipped
      if (stop) begin
         st_d.hs  = HS_IDLE;
         st_d.ptr = next_slot(st_d.last_sent);                                        // R2
      end else if (push_ready) begin
         st_d.ptr = next_slot(st_q.ptr);                                              // R4
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q           <= '0;
         st_q.ctrl      <= CTRL_RST;
         st_q.freq      <= FREQ_RST;
         st_q.mode      <= MODE_RST;
         st_q.aux       <= AUX_RST;
         st_q.ptr       <= PTR_RST;
         st_q.last_sent <= LAST_SENT_RST;
         st_q.hs        <= HS_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_dat_o  = st_q.rdat;
   assign wb_ack_o  = st_q.ack;
   assign dio_o     = st_q.dio;
   assign dio_oe_o  = (st_q.hs != HS_IDLE);                                           // R13
   assign dav_o     = (st_q.hs == HS_DRIVE);                                          // R14
   assign dav_oe_o  = (st_q.hs == HS_DRIVE);
   assign talking_o = st_q.talking;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic push_fire;
   assign push_fire = push_valid & push_ready;

   sequence talk_addr_seen;
      st_q.ctrl[CTRL_EN_BIT] && atn_act && dav_rise && pin_s.dio[6:5] == TALK_GRP &&
      pin_s.dio[4:0] == st_q.ctrl[4:0] && pin_s.dio[4:0] != UNTALK_ADDR;
   endsequence

   sequence byte_offered;
      $rose(dav_o);
   endsequence

   a_talk_start: assert property (talk_addr_seen |=> talking_o ##0 push_fire || atn_act) // R1
      else $error("own talk address did not start a transfer");

   a_resume_order: assert property (byte_offered |-> st_q.slot == next_slot(st_q.last_sent)) // R2
      else $error("byte offered out of slot order");

   a_header_bits: assert property (push_fire && push_item.slot == HDR_SLOT |->      // R3
      push_item.data[7:6] == HDR_TAG && push_item.data[4:0] == st_q.ctrl[4:0])
      else $error("header byte malformed");

   a_header_pins: assert property (dav_o && st_q.slot == HDR_SLOT |->               // R3
      dio_o[7:6] == HDR_TAG)
      else $error("header on lines without tag bits");

   // Consecutive loads must walk the slots, so eight parameters sit between headers
   a_slot_order: assert property (push_fire ##1 push_fire |->                        // R4
      push_item.slot == next_slot($past(push_item.slot)))
      else $error("frame slots loaded out of order");

   a_param_range: assert property (push_fire && push_item.slot >= CTL_SLOT |->      // R5
      push_item.data < PARAM_LIMIT)
      else $error("parameter byte could pose as header");

   a_detbw_layout: assert property (push_fire && push_item.slot == DETBW_SLOT |->   // R8
      push_item.data[7:5] <= BW_MAX &&
      (st_q.mode[5:3] > BW_MAX || push_item.data[7:5] == st_q.mode[5:3]))
      else $error("bandwidth field misplaced");

   a_det_codes: assert property (push_fire && push_item.slot == DETBW_SLOT |->      // R9
      (st_q.mode[2:0] != SEL_AM || push_item.data[4:0] == 5'h1D) &&
      (st_q.mode[2:0] != SEL_FM || push_item.data[4:0] == 5'h1C) &&
      (st_q.mode[2:0] != SEL_ISB || push_item.data[4:0] == 5'h02) &&
      (st_q.mode[2:0] != SEL_USB || push_item.data[4:0] == 5'h01) &&
      (st_q.mode[2:0] != SEL_LSB || push_item.data[4:0] == 5'h00))
      else $error("detection code wrong");

   a_fine_digit: assert property (push_fire && push_item.slot == FINE_SLOT |->      // R10
      (st_q.ctrl[CTRL_OPT_BIT] ? push_item.data <= 8'h09 : push_item.data == NO_OPT_BYTE))
      else $error("fine digit byte wrong");

   a_remote_bit: assert property (push_fire && push_item.slot == CTL_SLOT |->       // R11
      push_item.data[7] == pin_s.remote && !push_item.data[6])
      else $error("remote indicator bit wrong");

   a_bcd_digits: assert property (push_fire && (push_item.slot == FRQ_HI_SLOT ||    // R12
      push_item.slot == FRQ_MID_SLOT || push_item.slot == FRQ_LO_SLOT) |->
      push_item.data[7:4] <= BCD_MAX && push_item.data[3:0] <= BCD_MAX)
      else $error("frequency byte not packed BCD");

   a_atn_release: assert property (atn_act |=> !dio_oe_o && !dav_o)                // R13
      else $error("lines still driven under attention");

   a_dav_ready: assert property (byte_offered |-> $past(pin_s.rfd) && !$past(pin_s.dac)) // R14
      else $error("byte offered before listener ready");

   a_dav_held: assert property (dav_o && !pin_s.dac && !stop |=> dav_o)             // R14
      else $error("data valid dropped before acceptance");

endmodule // msf_monitor_frame_sender

//--- inc/msf_pkg.sv
// Constants, types and layouts shared by the monitor status frame sender
//
// Summary of operation
// [R1] Own talk address raises internal start request
// [R2] Each transfer resumes after last sent slot
// [R3] Header: address low, bits 7:6 set
// [R4] Header followed by exactly eight ordered parameters
// [R5] Parameter bytes never have both top bits (code: the fine slot sends NO_OPT_BYTE, 0xFF, when CTRL_OPT_BIT is clear)
// [R6] Listener skips bytes until one at least 192
// [R7] Listener subtracts 192 from header for address
// [R8] Detection low five bits, bandwidth high three
// [R9] Detection codes: AM 29, FM 28, INDEPENDENT_SIDEBAND_MODE 2...
// [R10] Fine digit max nine, else all ones
// [R11] Remote indicator in top bit, not writable
// [R12] Frequency bytes carry two packed BCD digits
// [R13] Attention asserted means address word, else data
// [R14] One full handshake per byte, await acceptance
package msf_pkg;

   // Frame layout
   localparam int          DATA_W       = 8;
   localparam int          SLOT_W       = 4;
   localparam int          PARAM_BYTES  = 8;
   localparam logic [3:0]  HDR_SLOT     = 4'h0;
   localparam logic [3:0]  FINE_SLOT    = 4'h1;
   localparam logic [3:0]  CTL_SLOT     = 4'h2;
   localparam logic [3:0]  FRQ_HI_SLOT  = 4'h3;
   localparam logic [3:0]  FRQ_MID_SLOT = 4'h4;
   localparam logic [3:0]  FRQ_LO_SLOT  = 4'h5;
   localparam logic [3:0]  DETBW_SLOT   = 4'h6;
   localparam logic [3:0]  BFO_SLOT     = 4'h7;
   localparam logic [3:0]  GAIN_SLOT    = 4'h8;
   localparam logic [3:0]  LAST_SLOT    = 4'h8;

   // Byte encodings
   localparam logic [1:0]  HDR_TAG      = 2'h3;
   localparam logic [1:0]  TALK_GRP     = 2'h2;
   localparam logic [4:0]  UNTALK_ADDR  = 5'h1F;
   localparam logic [7:0]  PARAM_LIMIT  = 8'hC0;
   localparam logic [7:0]  NO_OPT_BYTE  = 8'hFF;
   localparam logic [7:0]  GAIN_MAX     = 8'hBF;
   localparam logic [3:0]  BCD_MAX      = 4'h9;
   localparam logic [2:0]  BW_MAX       = 3'h5;
   localparam logic [1:0]  GAIN_MODE_MAX = 2'h2;
   localparam logic [1:0]  MSD_MAX      = 2'h2;
   localparam logic [4:0]  DET_LSB      = 5'h00;
   localparam logic [4:0]  DET_USB      = 5'h01;
   localparam logic [4:0]  DET_ISB      = 5'h02;
   localparam logic [4:0]  DET_CW       = 5'h0B;
   localparam logic [4:0]  DET_FM       = 5'h1C;
   localparam logic [4:0]  DET_AM       = 5'h1D;
   localparam logic [2:0]  SEL_LSB      = 3'h0;
   localparam logic [2:0]  SEL_USB      = 3'h1;
   localparam logic [2:0]  SEL_ISB      = 3'h2;
   localparam logic [2:0]  SEL_CW       = 3'h3;
   localparam logic [2:0]  SEL_FM       = 3'h4;
   localparam logic [2:0]  SEL_AM       = 3'h5;

   // Register map (byte addresses)
   localparam int          ADR_W        = 8;
   localparam logic [7:0]  OFF_CTRL     = 8'h00;
   localparam logic [7:0]  OFF_FREQ     = 8'h04;
   localparam logic [7:0]  OFF_MODE     = 8'h08;
   localparam logic [7:0]  OFF_AUX      = 8'h0C;
   localparam logic [7:0]  OFF_STATUS   = 8'h10;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [31:0] FREQ_RST     = 32'h0000_0000;
   localparam logic [31:0] MODE_RST     = 32'h0000_0005;
   localparam logic [31:0] AUX_RST      = 32'h0000_0000;

   // Field positions
   localparam int          CTRL_ADDR_LSB = 0;
   localparam int          CTRL_B5_BIT   = 5;
   localparam int          CTRL_OPT_BIT  = 6;
   localparam int          CTRL_EN_BIT   = 7;
   localparam int          MODE_DET_LSB  = 0;
   localparam int          MODE_BW_LSB   = 3;
   localparam int          MODE_GAIN_LSB = 6;
   localparam int          MODE_NEG_BIT  = 8;

   localparam logic [3:0]  PTR_RST       = HDR_SLOT;
   localparam logic [3:0]  LAST_SENT_RST = LAST_SLOT;
   localparam int          FIFO_DEPTH    = 8;

   typedef enum logic [1:0] {HS_IDLE, HS_WAIT_RFD, HS_DRIVE, HS_RELEASE} msf_hs_t;

   typedef struct packed {
      logic [3:0] slot;
      logic [7:0] data;
   } msf_item_t;

   typedef struct packed {
      logic       remote;
      logic       atn_n;
      logic       dav;
      logic       rfd;
      logic       dac;
      logic [7:0] dio;
   } msf_pins_t;

endpackage

//--- rtl/msf_sync.sv
// Three-stage pin synchroniser; a bit changes once stages two and three agree
`timescale 1ns/10ps
module msf_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Pins and synchronised levels
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] out;
   } msf_sync_state_t;

   msf_sync_state_t st_q;
   msf_sync_state_t st_d;
   logic [WIDTH-1:0] agree;

   always_comb begin
      st_d     = st_q;
      agree    = ~(st_q.s2 ^ st_q.s3);
      st_d.s1  = async_i;
      st_d.s2  = st_q.s1;
      st_d.s3  = st_q.s2;
      st_d.out = (st_q.out & ~agree) | (st_q.s3 & agree);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_o = st_q.out;
endmodule // msf_sync

//--- rtl/msf_fifo.sv
// Byte FIFO between the frame builder and the bus handshake engine
`timescale 1ns/10ps
module msf_fifo import msf_pkg::*; #(
   parameter int WIDTH = 12,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             flush_i,
   // Fill side
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   // Drain side
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [CW-1:0]               cnt;
   } msf_fifo_state_t;

   msf_fifo_state_t st_q;
   msf_fifo_state_t st_d;
   logic            push;
   logic            pop;

   always_comb begin
      st_d = st_q;
      push = in_valid_i & in_ready_o;
      pop  = out_valid_o & out_ready_i;
      if (flush_i) begin
         st_d.wr  = '0;
         st_d.rd  = '0;
         st_d.cnt = '0;
      end else begin
         if (push) begin
            st_d.mem[st_q.wr] = in_data_i;
            st_d.wr = (st_q.wr == AW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
         end
         if (pop) begin
            st_d.rd = (st_q.rd == AW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
         end
         case ({push, pop})
            2'b10:   st_d.cnt = st_q.cnt + 1'b1;
            2'b01:   st_d.cnt = st_q.cnt - 1'b1;
            default: st_d.cnt = st_q.cnt;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign in_ready_o  = (st_q.cnt != CW'(DEPTH));
   assign out_valid_o = (st_q.cnt != '0);
   assign out_data_o  = st_q.mem[st_q.rd];
endmodule // msf_fifo

//--- test/msf_listener.sv
// Listener partner: accepts talker bytes with an adjustable delay
`timescale 1ns/10ps
module msf_listener (
   // Clock and pacing
   input  wire logic       clk_i,
   input  wire logic       hold_i,
   input  wire logic [1:0] slow_i,
   // Handshake and data
   input  wire logic       dav_i,
   input  wire logic [7:0] dio_i,
   output logic            rfd_o,
   output logic            dac_o,
   output logic            got_o,
   output logic      [7:0] byte_o
);
   initial begin
      {rfd_o, dac_o, got_o, byte_o} = '0;
      forever begin
         @(posedge clk_i);
         // Hold keeps ready low so the talker stalls with a byte pending
         if (!hold_i) begin
            rfd_o <= 1'b1;
            while (dav_i !== 1'b1) @(posedge clk_i);
            rfd_o  <= 1'b0;
            byte_o <= dio_i;
            got_o  <= 1'b1;
            @(posedge clk_i);
            got_o <= 1'b0;
            repeat (slow_i) @(posedge clk_i);
            dac_o <= 1'b1;
            while (dav_i !== 1'b0) @(posedge clk_i);
            dac_o <= 1'b0;
         end
      end
   end
endmodule // msf_listener

//--- test/test_monitor_status_frame_sender.sv
// Testbench: register setup, talk sessions and frame byte model
`timescale 1ns/10ps
module test_monitor_status_frame_sender import msf_pkg::*;;
   logic clk_i, rst_i, cyc, stb, we, atn_n, dav, rem, hold, rfd, dac, got, dav_o, oe, tlk, ack;
   logic dav_oe;
   logic [7:0] adr, ctl, dout, dio, byt;
   logic [31:0] wd, rdat, q, rnd, ctrl, freq, mode, aux;
   logic [1:0] slow;
   int fail_count, check_count, sl;
   assign dio = oe ? dout : ctl;
   msf_monitor_frame_sender u_msf_monitor_frame_sender (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .dio_i(dio), .dio_o(dout),
      .dio_oe_o(oe), .atn_n_i(atn_n), .dav_i(dav), .dav_o(dav_o), .dav_oe_o(dav_oe),
      .rfd_i(rfd), .dac_i(dac), .remote_i(rem), .talking_o(tlk));
   msf_listener u_msf_listener (.clk_i(clk_i), .hold_i(hold), .slow_i(slow), .dav_i(dav_o),
      .dio_i(dio), .rfd_o(rfd), .dac_o(dac), .got_o(got), .byte_o(byt));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wait_for(input logic which);
      int k;
      k = 0;
      do begin @(posedge clk_i); k++; end while ((which ? got : ack) !== 1'b1 && k < 900);
      if (k >= 900) begin fail_count++; test_done; end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
      wait_for(1'b0);
      q = rdat;
      {cyc, stb} <= 2'b00;
      @(posedge clk_i);
   endtask
   // Controller address word: data lines are released to an inverted value afterwards
   task automatic addr_word(input logic [7:0] w);
      {atn_n, ctl} <= {1'b0, w};
      repeat (5) @(posedge clk_i);
      dav <= 1'b1;
      repeat (6) @(posedge clk_i);
      dav <= 1'b0;
      repeat (6) @(posedge clk_i);
      {atn_n, ctl} <= {1'b1, ~w};
      repeat (2) @(posedge clk_i);
   endtask
   function automatic logic [7:0] exp_byte(input int s);
      logic [3:0] n [8];
      logic [4:0] det [8];
      det = '{5'd0, 5'd1, 5'd2, DET_CW, 5'd28, 5'd29, 5'd29, 5'd29};
      for (int k = 0; k < 8; k++) n[k] = freq[4*k+:4] > 9 ? 4'h9 : freq[4*k+:4];
      case (s)
         0: return {2'b11, ctrl[5:0]};
         1: return ctrl[6] ? {4'h0, n[0]} : 8'hFF;
         2: return {rem, 2'b00, mode[8], mode[7:6] == 3 ? 2'd2 : mode[7:6],
                    freq[29:28] == 3 ? 2'd2 : freq[29:28]};
         3: return {n[6], n[5]};
         4: return {n[4], n[3]};
         5: return {n[2], n[1]};
         6: return {mode[5:3] > 5 ? 3'd5 : mode[5:3], det[mode[2:0]]};
         7: return aux[7:0];
         default: return aux[15:8] > 191 ? 8'd191 : aux[15:8];
      endcase
   endfunction
   // Thirty-two shifts per call so every bit of the word moves between scenarios
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      for (int k = 0; k < 32; k++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s;
   endfunction
   task automatic sess(input int n);
      addr_word({3'b010, ctrl[4:0]});
      chk(tlk, 1);
      hold <= 1'b0;
      repeat (n) begin
         wait_for(1'b1);
         chk(byt, exp_byte(sl));
         chk(byt >= 8'hC0, sl == 0 || (sl == 1 && !ctrl[6]));
         if (sl == 0) chk(byt - 8'hC0, ctrl[5:0]);
         chk({dav_oe, oe}, 2'b11);
         sl = (sl + 1) % 9;
      end
      hold <= 1'b1;
      repeat (30) @(posedge clk_i);
      addr_word(8'h5F);
      chk(tlk, 0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {cyc, stb, we, adr, wd, dav, ctl, rem, slow} = '0;
      {rst_i, atn_n, hold} = 3'b111;
      {fail_count, check_count, sl, rnd} = {96'h0, 32'h8f54};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, OFF_CTRL, 0); chk(q, CTRL_RST);
      wb(1'b0, OFF_STATUS, 0); chk(q, {16'h0000, 4'h0, LAST_SENT_RST, PTR_RST, 4'h0});
      wb(1'b0, OFF_MODE, 0); chk(q, MODE_RST);
      wb(1'b0, OFF_AUX, 0); chk(q, AUX_RST);
      wb(1'b0, 8'h14, 0); chk(q, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         ctrl = {24'h0, 1'b1, i[0], rnd[5], 1'b0, rnd[3:0]};
         {freq, mode} = {rnd, 23'h0, rnd[8:3], i[2:0]};
         aux = {16'h0, rnd[23:16], 1'b0, rnd[6:4], 1'b0, rnd[2:0]};
         {rem, slow} <= {i[1], rnd[27:26]};
         wb(1'b1, OFF_CTRL, ctrl); wb(1'b1, OFF_FREQ, freq);
         wb(1'b1, OFF_MODE, mode); wb(1'b1, OFF_AUX, aux);
         wb(1'b0, OFF_MODE, 0); chk(q, mode);
         sess(5 + i);
      end
      test_done;
   end
endmodule // test_monitor_status_frame_sender
